// *** include/mfp_pkg.sv ***
/*
 * mfp_pkg: register map, field layout, function codes and pin-command types for the
 * multi-function pin controller. Assumes a 32-bit Avalon-MM slave with word addressing
 * of byte offsets and a four-channel converter core around it.
 */
package mfp_pkg;

    localparam int unsigned NUM_CH = 4;

    // byte offsets of the register words
    localparam logic [3:0] OFS_PIN_CFG   = 4'h0;
    localparam logic [3:0] OFS_SW_CTRL   = 4'h4;
    localparam logic [3:0] OFS_STATUS    = 4'h8;
    localparam logic [3:0] OFS_CH_CFG    = 4'hc;

    // pin configuration word fields
    localparam int unsigned POS_IN_EN    = 0;
    localparam int unsigned POS_OUT_EN   = 1;
    localparam int unsigned POS_NV_RST   = 2;
    localparam int unsigned POS_IN_FUNC  = 4;
    localparam int unsigned POS_OUT_FUNC = 8;
    localparam int unsigned POS_CH_SEL   = 12;

    // channel configuration word fields
    localparam int unsigned POS_SYNC_EN  = 0;
    localparam int unsigned POS_PULLDOWN = 4;

    // software control word fields
    localparam int unsigned POS_SW_IPDN  = 0;
    localparam int unsigned POS_SW_VPDN  = 4;
    localparam int unsigned POS_SW_WAVE  = 8;
    localparam int unsigned POS_SW_NVBLK = 12;
    localparam int unsigned POS_SW_WRBLK = 13;

    localparam logic [31:0] RST_PIN_CFG  = 32'h0000_0000;
    localparam logic [31:0] RST_SW_CTRL  = 32'h0000_0000;
    localparam logic [31:0] RST_CH_CFG   = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

    // input function codes
    localparam logic [3:0] IF_NONE       = 4'h0;
    localparam logic [3:0] IF_FAULT_DUMP = 4'h2;
    localparam logic [3:0] IF_CURRENT_OUTPUT_PD    = 4'h3;
    localparam logic [3:0] IF_VOLTAGE_OUTPUT_PD    = 4'h4;
    localparam logic [3:0] IF_PROTECT    = 4'h5;
    localparam logic [3:0] IF_CLEAR      = 4'h7;
    localparam logic [3:0] IF_SYNC_LOAD  = 4'h8;
    localparam logic [3:0] IF_WAVE       = 4'h9;
    localparam logic [3:0] IF_RESET      = 4'hb;
    localparam logic [3:0] IF_NV_LOCK    = 4'hc;
    localparam logic [3:0] IF_WR_LOCK    = 4'hd;

    // output function codes
    localparam logic [3:0] OF_NV_BUSY    = 4'h1;
    localparam logic [3:0] OF_BUSY_LO    = 4'h4;
    localparam logic [3:0] OF_BUSY_HI    = 4'h7;
    localparam logic [3:0] OF_WIN_LO     = 4'h8;
    localparam logic [3:0] OF_WIN_HI     = 4'hb;

    // cycles the pin synchroniser needs to flush its reset value at power-up
    localparam logic [1:0] SETTLE_CNT    = 2'h3;

    typedef struct packed {
        logic                fault_dump;
        logic                protect;
        logic                clear_action;
        logic [NUM_CH-1:0]   sync_load;
        logic                device_reset;
    } mfp_pulse_t;

    typedef struct packed {
        logic [NUM_CH-1:0]   current_output_pd;
        logic [NUM_CH-1:0]   voltage_output_pd;
        logic [NUM_CH-1:0]   voltage_pulldown_sel;
        logic [NUM_CH-1:0]   wave_run;
        logic                nv_prog_blocked;
        logic                reg_write_blocked;
    } mfp_level_t;

    typedef struct packed {
        logic                nonvolatile_busy;
        logic [NUM_CH-1:0]   channel_busy;
        logic [NUM_CH-1:0]   window_compare_result;
    } mfp_status_t;

endpackage

// *** design/mfp_pin_ctrl.sv ***
/*
 * mfp_pin_ctrl: logic behind the single multi-function pin. Holds the pin configuration,
 * synchronises and edge-detects the pin, maps pin events and software bits onto
 * per-channel and global actions, and drives the pin from core status in output mode.
 * Assumes an Avalon-MM master on clk, and a core that honours the action outputs.
 * The nonvolatile copy of the configuration is presented on nv_pin_cfg by the core.
 */
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps

module mfp_pin_ctrl
    import mfp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [3:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               pin_in,
    output logic                    pin_out,
    output logic                    pin_oe,
    input  wire logic               boot_done,
    input  wire logic [31:0]        nv_pin_cfg,
    input  wire mfp_status_t        core_status,
    output mfp_pulse_t              act_pulse,
    output mfp_level_t              act_level
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic chan_func(input logic [3:0] code);
        return code == IF_CURRENT_OUTPUT_PD || code == IF_VOLTAGE_OUTPUT_PD || code == IF_WAVE;
    endfunction

    typedef enum logic [1:0] {ST_RESET, ST_POWERUP, ST_RUN} mfp_state_t;

    logic [31:0]         pin_cfg_q,  pin_cfg_d;
    logic [31:0]         sw_ctrl_q,  sw_ctrl_d;
    logic [31:0]         ch_cfg_q,   ch_cfg_d;
    logic [31:0]         rdata_q,    rdata_d;
    logic                ack_q,      ack_d;
    logic [2:0]          sync_q,     sync_d;
    logic                pin_lvl_q,  pin_lvl_d;
    mfp_state_t          state_q,    state_d;
    logic [NUM_CH-1:0]   ipd_q,      ipd_d;
    logic [NUM_CH-1:0]   vpd_q,      vpd_d;
    logic [NUM_CH-1:0]   wave_q,     wave_d;
    logic                nvblk_q,    nvblk_d;
    logic                wrblk_q,    wrblk_d;
    logic [1:0]          settle_q,   settle_d;
    mfp_pulse_t          pulse_q,    pulse_d;
    mfp_level_t          level_q,    level_d;
    logic                pout_q,     pout_d;
    logic                poe_q,      poe_d;

    logic                in_en;
    logic                out_en;
    logic [3:0]          in_func;
    logic [3:0]          out_func;
    logic [NUM_CH-1:0]   ch_sel;
    logic [NUM_CH-1:0]   sync_en;
    logic                fall;
    logic                rise;
    logic                req;

    assign in_en    = pin_cfg_q[POS_IN_EN];
    assign out_en   = pin_cfg_q[POS_OUT_EN] & ~in_en;
    assign in_func  = in_en ? pin_cfg_q[POS_IN_FUNC +: 4] : IF_NONE;
    assign out_func = pin_cfg_q[POS_OUT_FUNC +: 4];
    assign ch_sel   = pin_cfg_q[POS_CH_SEL +: NUM_CH];
    assign sync_en  = ch_cfg_q[POS_SYNC_EN +: NUM_CH];
    assign req      = (avs_read | avs_write) & ~ack_q;

    // second and third stages agree before a change counts; stage one feeds stage two only
    always_comb begin
        sync_d    = {sync_q[1:0], pin_in};
        pin_lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : pin_lvl_q;
    end

    assign fall = pin_lvl_q & ~pin_lvl_d;
    assign rise = ~pin_lvl_q & pin_lvl_d;

    // register bus: one wait cycle, then an acknowledge cycle
    always_comb begin
        pin_cfg_d = pin_cfg_q;
        sw_ctrl_d = sw_ctrl_q;
        ch_cfg_d  = ch_cfg_q;
        rdata_d   = rdata_q;
        ack_d     = req;
        if (req && avs_write && !wrblk_q) begin
            unique case (avs_address)
                OFS_PIN_CFG: pin_cfg_d = merge_bytes(pin_cfg_q, avs_writedata, avs_byteenable);
                OFS_SW_CTRL: sw_ctrl_d = merge_bytes(sw_ctrl_q, avs_writedata, avs_byteenable);
                OFS_CH_CFG:  ch_cfg_d  = merge_bytes(ch_cfg_q, avs_writedata, avs_byteenable);
                default: ;
            endcase
        end
        if (req && avs_read) begin
            unique case (avs_address)
                OFS_PIN_CFG: rdata_d = pin_cfg_q;
                OFS_SW_CTRL: rdata_d = sw_ctrl_q;
                OFS_CH_CFG:  rdata_d = ch_cfg_q;
                OFS_STATUS:  rdata_d = {8'h00, wave_q, vpd_q, ipd_q,
                                        2'b00, wrblk_q, nvblk_q, 2'b00, state_q, 3'b000,
                                        pin_lvl_q};
                default:     rdata_d = UNMAPPED_RD;
            endcase
        end
        if (state_q == ST_RESET) begin
            // a reset mapping survives only when the nonvolatile copy carries it
            pin_cfg_d = nv_pin_cfg[POS_NV_RST] ? nv_pin_cfg : RST_PIN_CFG;
        end
    end

    // pin and software actions
    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        ipd_d   = ipd_q;
        vpd_d   = vpd_q;
        wave_d  = wave_q;
        nvblk_d = nvblk_q;
        wrblk_d = wrblk_q;
        pulse_d = '0;
        // software bits are ignored while the pin owns the function
        if (in_func != IF_CURRENT_OUTPUT_PD) ipd_d  = sw_ctrl_q[POS_SW_IPDN +: NUM_CH];
        if (in_func != IF_VOLTAGE_OUTPUT_PD) vpd_d  = sw_ctrl_q[POS_SW_VPDN +: NUM_CH];
        if (in_func != IF_WAVE)    wave_d = sw_ctrl_q[POS_SW_WAVE +: NUM_CH];
        if (in_func != IF_NV_LOCK) nvblk_d = sw_ctrl_q[POS_SW_NVBLK];
        if (in_func != IF_WR_LOCK) wrblk_d = sw_ctrl_q[POS_SW_WRBLK];
        unique case (state_q)
            ST_RESET: state_d = ST_POWERUP;
            ST_POWERUP: begin
                // the level flop still holds its reset value until the synchroniser flushes
                if (settle_q != SETTLE_CNT) begin
                    settle_d = settle_q + 2'h1;
                end
                // once, at power-up, the settled level runs its command
                if (boot_done && settle_q == SETTLE_CNT) begin
                    state_d = ST_RUN;
                    unique case (in_func)
                        IF_CURRENT_OUTPUT_PD: ipd_d  = chan_func(in_func) ? ({NUM_CH{~pin_lvl_q}} & ch_sel)
                                                               | (ipd_q & ~ch_sel) : ipd_q;
                        IF_VOLTAGE_OUTPUT_PD: vpd_d  = ({NUM_CH{~pin_lvl_q}} & ch_sel) | (vpd_q & ~ch_sel);
                        IF_WAVE:    wave_d = ({NUM_CH{pin_lvl_q}} & ch_sel) | (wave_q & ~ch_sel);
                        IF_NV_LOCK: nvblk_d = pin_lvl_q;
                        IF_WR_LOCK: wrblk_d = pin_lvl_q;
                        default: ;
                    endcase
                end
            end
            ST_RUN: begin
                if (fall || rise) begin
                    unique case (in_func)
                        IF_FAULT_DUMP: pulse_d.fault_dump   = fall;
                        IF_PROTECT:    pulse_d.protect      = fall;
                        IF_CLEAR:      pulse_d.clear_action = fall;
                        IF_CURRENT_OUTPUT_PD:    ipd_d  = fall ? ipd_q | ch_sel : ipd_q & ~ch_sel;
                        IF_WAVE:       wave_d = fall ? wave_q & ~ch_sel : wave_q | ch_sel;
                        IF_VOLTAGE_OUTPUT_PD:    vpd_d  = fall ? vpd_q | ch_sel : vpd_q & ~ch_sel;
                        // gated by the sync enable of each selected channel
                        IF_SYNC_LOAD:  pulse_d.sync_load = fall ? (sync_en & ch_sel) : '0;
                        IF_RESET:      pulse_d.device_reset = rise;
                        IF_NV_LOCK:    nvblk_d = rise;
                        IF_WR_LOCK:    wrblk_d = rise;
                        default: ;
                    endcase
                end
            end
            default: state_d = ST_RESET;
        endcase
        level_d.current_output_pd    = ipd_q;
        level_d.voltage_output_pd    = vpd_q;
        level_d.voltage_pulldown_sel = ch_cfg_q[POS_PULLDOWN +: NUM_CH] & vpd_q;
        level_d.wave_run             = wave_q;
        level_d.nv_prog_blocked      = nvblk_q;
        level_d.reg_write_blocked    = wrblk_q;
    end

    // output mode status selection
    always_comb begin
        poe_d  = out_en;
        pout_d = 1'b0;
        if (out_en) begin
            if (out_func == OF_NV_BUSY) begin
                pout_d = core_status.nonvolatile_busy;
            end else if (out_func >= OF_BUSY_LO && out_func <= OF_BUSY_HI) begin
                pout_d = core_status.channel_busy[2'(out_func - OF_BUSY_LO)];
            end else if (out_func >= OF_WIN_LO && out_func <= OF_WIN_HI) begin
                pout_d = core_status.window_compare_result[2'(out_func - OF_WIN_LO)];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_cfg_q <= RST_PIN_CFG;
            sw_ctrl_q <= RST_SW_CTRL;
            ch_cfg_q  <= RST_CH_CFG;
            rdata_q   <= '0;
            ack_q     <= 1'b0;
            sync_q    <= 3'b111;
            pin_lvl_q <= 1'b1;
            state_q   <= ST_RESET;
            ipd_q     <= '0;
            vpd_q     <= '0;
            wave_q    <= '0;
            nvblk_q   <= 1'b0;
            wrblk_q   <= 1'b0;
            settle_q  <= '0;
            pulse_q   <= '0;
            level_q   <= '0;
            pout_q    <= 1'b0;
            poe_q     <= 1'b0;
        end else begin
            pin_cfg_q <= pin_cfg_d;
            sw_ctrl_q <= sw_ctrl_d;
            ch_cfg_q  <= ch_cfg_d;
            rdata_q   <= rdata_d;
            ack_q     <= ack_d;
            sync_q    <= sync_d;
            pin_lvl_q <= pin_lvl_d;
            state_q   <= state_d;
            ipd_q     <= ipd_d;
            vpd_q     <= vpd_d;
            wave_q    <= wave_d;
            nvblk_q   <= nvblk_d;
            wrblk_q   <= wrblk_d;
            settle_q  <= settle_d;
            pulse_q   <= pulse_d;
            level_q   <= level_d;
            pout_q    <= pout_d;
            poe_q     <= poe_d;
        end
    end

    // waitrequest low only in the acknowledge cycle; the flop is inverted ack
    logic wait_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~ack_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pin_out         = pout_q;
    assign pin_oe          = poe_q;
    assign act_pulse       = pulse_q;
    assign act_level       = level_q;

endmodule

// *** tb/mfp_pin_ctrl_checker.sv ***
/*
 * mfp_pin_ctrl_checker: port-level assertions for the multi-function pin controller.
 * Assumes the bench holds bus requests until acked and spaces pin edges well apart.
 */
`timescale 1ns/100ps
module mfp_pin_ctrl_checker
    import mfp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        pin_in,
    input wire logic        pin_out,
    input wire logic        pin_oe,
    input wire logic        boot_done,
    input wire logic [31:0] nv_pin_cfg,
    input wire mfp_status_t core_status,
    input wire mfp_pulse_t  act_pulse,
    input wire mfp_level_t  act_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic req;
    logic edge_act;
    assign req = avs_read | avs_write;
    // reset pulse is excluded: it fires at the rising end of its low pulse
    assign edge_act = act_pulse.fault_dump | act_pulse.protect | act_pulse.clear_action
                    | (|act_pulse.sync_load);

    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not acked after one wait cycle");
    a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("ack stood longer than one cycle");
    a_idle_stall: assert property (!req && avs_waitrequest |=> avs_waitrequest)
        else $error("ack without a request");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address == 4'h2
        |=> avs_readdata == UNMAPPED_RD)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_reset_quiet: assert property ($rose(rst_n) |-> avs_waitrequest && !pin_oe
        && act_pulse == '0 && act_level == '0)
        else $error("outputs not quiet after reset");
    a_pulse_single: assert property (act_pulse != '0 |=> act_pulse == '0)
        else $error("action pulse longer than one cycle");
    a_fall_only: assert property (edge_act |-> !pin_in && $past(pin_in, 3) == 1'b0)
        else $error("edge action without a falling pin");
    a_preboot_idle: assert property (!boot_done |-> act_pulse == '0)
        else $error("action pulse before boot");

    c_read_ack: cover property (avs_read && !avs_waitrequest);
    c_write_ack: cover property (avs_write && !avs_waitrequest);
    c_fault_dump: cover property (act_pulse.fault_dump);
    c_sync_load: cover property (act_pulse.sync_load != 4'h0);
    c_dev_reset: cover property (act_pulse.device_reset);
endmodule

bind mfp_pin_ctrl mfp_pin_ctrl_checker i_chk (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .boot_done(boot_done), .nv_pin_cfg(nv_pin_cfg),
    .core_status(core_status), .act_pulse(act_pulse), .act_level(act_level));

// *** tb/mfp_pin_drv.sv ***
/*
 * mfp_pin_drv: external switch on the multi-function pin, prompt or slow.
 * Assumes the bench sets the wanted level; resolves the wire with the device drive.
 */
`timescale 1ns/100ps
module mfp_pin_drv (
    input  wire logic clk,
    input  wire logic lvl,
    input  wire logic slow,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin
);
    logic [3:0] dly_q = 4'hf;
    // the switch always holds a definite level, it never floats the pin
    always_ff @(posedge clk) dly_q <= {dly_q[2:0], lvl};
    // a low level followed by a high one forms the reset pulse
    assign pin = pin_oe ? pin_out : (slow ? dly_q[3] : dly_q[0]);
endmodule

// *** tb/multi_function_pin_ctrl_tb_top.sv ***
/*
 * multi_function_pin_ctrl_tb_top: self-checking bench for the pin controller.
 * Assumes the one-wait-cycle bus of the controller and the external switch model.
 */
`timescale 1ns/100ps
module multi_function_pin_ctrl_tb_top;
    import mfp_pkg::*;
    logic        clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, lvl = 1, slow = 0;
    logic        boot_done = 1, avs_waitrequest, pin_in, pin_out, pin_oe;
    logic [3:0]  avs_address = 4'h0, ch, sy;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, seed = 32'h822e;
    logic [31:0] nv_pin_cfg = 32'h0000_00b1;
    logic [3:0]  sl_acc = 4'h0, codes[3], cc[3];
    mfp_status_t core_status = '0;
    mfp_pulse_t  act_pulse;
    mfp_level_t  act_level;
    int          n_errors = 0, compares = 0, c_fd = 0, c_pr = 0, c_cl = 0, c_rs = 0;
    int          m[3] = '{0, 0, 0};

    mfp_pin_ctrl i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .boot_done(boot_done),
        .nv_pin_cfg(nv_pin_cfg), .core_status(core_status), .act_pulse(act_pulse),
        .act_level(act_level));
    mfp_pin_drv i_pin (.clk(clk), .lvl(lvl), .slow(slow), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin(pin_in));

    initial forever #5 clk = ~clk;
    always @(posedge clk) if (rst_n) begin
        c_fd += int'(act_pulse.fault_dump);
        c_pr += int'(act_pulse.protect);
        c_cl += int'(act_pulse.clear_action);
        c_rs += int'(act_pulse.device_reset);
        sl_acc |= act_pulse.sync_load;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] lv();
        return 32'({act_level.current_output_pd, act_level.voltage_output_pd, act_level.wave_run});
    endfunction
    task automatic summarize();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
        if (n >= 40) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic in_cfg(input logic [3:0] c, input logic [3:0] s);
        bus(1'b1, OFS_PIN_CFG, 32'h1 | 32'(c) << POS_IN_FUNC | 32'(s) << POS_CH_SEL);
    endtask
    // fixed wait covers sync, edge detect and the slow switch
    task automatic step(input logic v);
        lvl <= v;
        repeat (12) @(posedge clk);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    initial begin
        codes = '{IF_FAULT_DUMP, IF_PROTECT, IF_CLEAR};
        cc = '{IF_CURRENT_OUTPUT_PD, IF_VOLTAGE_OUTPUT_PD, IF_WAVE};
        do_reset();
        bus(1'b0, OFS_PIN_CFG, 32'h0);
        chk(q, RST_PIN_CFG);
        bus(1'b0, OFS_SW_CTRL, 32'h0);
        chk(q, RST_SW_CTRL);
        bus(1'b0, OFS_CH_CFG, 32'h0);
        chk(q, RST_CH_CFG);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, UNMAPPED_RD);
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            in_cfg(codes[k], 4'h0);
            step(1'b0);
            m[k]++;
            step(1'b1);
            chk(32'({8'(c_fd), 8'(c_pr), 8'(c_cl)}), 32'({8'(m[0]), 8'(m[1]), 8'(m[2])}));
        end
        chk(32'(pin_oe), 32'h0);
        $display("test global done");
        for (int k = 0; k < 3; k++) begin
            ch = 4'(xs()) | 4'h1;
            in_cfg(cc[k], ch);
            step(1'b0);
            chk(lv(), k == 0 ? 32'(ch) << 8 : k == 1 ? 32'(ch) << 4 : 32'h0);
            if (k == 0) begin
                bus(1'b1, OFS_SW_CTRL, 32'hf);
                chk(lv(), 32'(ch) << 8);
                bus(1'b1, OFS_SW_CTRL, 32'h0);
            end
            if (k == 1) begin
                // pulldown follows only the selected, powered-down channels
                bus(1'b1, OFS_CH_CFG, 32'h50);
                chk(32'(act_level.voltage_pulldown_sel), 32'(ch & 4'h5));
            end
            step(1'b1);
            chk(lv(), k == 2 ? 32'(ch) : 32'h0);
        end
        $display("test channel done");
        sy = 4'(xs()) | 4'h1;
        ch = 4'(xs()) | 4'h1;
        bus(1'b1, OFS_CH_CFG, 32'(sy));
        in_cfg(IF_SYNC_LOAD, ch);
        sl_acc = 4'h0;
        step(1'b0);
        step(1'b1);
        chk(32'(sl_acc), 32'(sy & ch));
        $display("test sync done");
        for (int k = 0; k < 2; k++) begin
            in_cfg(k ? IF_WR_LOCK : IF_NV_LOCK, 4'h0);
            step(1'b0);
            chk(32'({act_level.nv_prog_blocked, act_level.reg_write_blocked}), 32'h0);
            step(1'b1);
            chk(32'({act_level.nv_prog_blocked, act_level.reg_write_blocked}), k ? 1 : 2);
        end
        bus(1'b1, OFS_CH_CFG, 32'h55);
        bus(1'b0, OFS_CH_CFG, 32'h0);
        chk(q, 32'(sy));
        step(1'b0);
        $display("test lock done");
        for (int oc = 1; oc < 12; oc++) begin
            if (oc == 2 || oc == 3)
                continue;
            core_status <= mfp_status_t'(9'(xs()));
            bus(1'b1, OFS_PIN_CFG, 32'h2 | 32'(oc) << POS_OUT_FUNC);
            repeat (2) @(posedge clk);
            chk(32'({pin_oe, pin_out}), 32'({1'b1, oc == 1 ? core_status.nonvolatile_busy
                : oc < 8 ? core_status.channel_busy[oc-4]
                : core_status.window_compare_result[oc-8]}));
        end
        $display("test output done");
        slow <= 1'b1;
        // leave output mode and let the pin settle high before mapping reset
        bus(1'b1, OFS_PIN_CFG, 32'h0);
        step(1'b1);
        in_cfg(IF_RESET, 4'h0);
        step(1'b0);
        chk(32'(c_rs), 32'h0);
        step(1'b1);
        chk(32'(c_rs), 32'h1);
        $display("test device reset done");
        nv_pin_cfg <= 32'h0000_5035;
        boot_done <= 1'b0;
        slow <= 1'b0;
        lvl <= 1'b0;
        do_reset();
        bus(1'b0, OFS_PIN_CFG, 32'h0);
        chk(q, 32'h0000_5035);
        step(1'b1);
        step(1'b0);
        chk(lv(), 32'h0);
        boot_done <= 1'b1;
        repeat (12) @(posedge clk);
        chk(lv(), 32'h500);
        $display("test power-up done");
        summarize();
    end
endmodule
